// ===== verilog/pmi_pkg.sv
// constants, types and register map shared by the MAC data interface
package pmi_pkg;

  typedef enum logic [1:0] {SPD_10, SPD_100, SPD_1000} pmi_speed_e;

  // register offsets
  localparam logic [15:0] REG_IF_CTRL = 16'h0032;
  localparam logic [15:0] REG_IF_DELAY = 16'h0086;

  // interface_control fields
  localparam int CTL_RX_SHIFT_BIT = 0;
  localparam int CTL_TX_SHIFT_BIT = 1;
  localparam int CTL_RGMII_EN_BIT = 7;
  localparam int CTL_COL_BIT = 10;
  localparam int CTL_CRS_BIT = 11;
  localparam int CTL_SPEED_LSB = 12;
  localparam logic [15:0] CTL_WR_MASK = 16'h0083;
  localparam logic [15:0] CTL_RESET = 16'h0080;

  // interface_delay_control fields: per path 4-bit skew code
  localparam int DLY_RX_LSB = 0;
  localparam int DLY_TX_LSB = 4;
  localparam int DLY_CODE_W = 4;
  localparam logic [15:0] DLY_WR_MASK = 16'h00ff;
  localparam logic [15:0] DLY_RESET = 16'h0000;

  // skew step in picoseconds per code
  localparam logic [11:0] SKEW_STEP_PS = 12'h0fa;

  // receive clock half periods in system clocks per speed
  localparam logic [4:0] HALF_1000 = 5'h01;
  localparam logic [4:0] HALF_100 = 5'h02;
  localparam logic [4:0] HALF_10 = 5'h14;

  // receive buffer: error flag above one data byte
  localparam int FIFO_W = 9;
  localparam int FIFO_D = 16;

endpackage

// ===== verilog/pmi_mac_if.sv
// MAC data interface: pin sampling, rx clock, data paths, carrier and collision
`timescale 1ns/10ps

module pmi_fifo #(
  parameter int W = 9,
  parameter int D = 16
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
  } pmi_fifo_s;

  pmi_fifo_s st;
  pmi_fifo_s next_st;
  logic push;
  logic pop;

  assign in_ready = (st.count != (AW+1)'(D));
  assign out_valid = (st.count != '0);
  assign out_data = st.mem[st.rptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.mem[st.wptr] = in_data;
      next_st.wptr = st.wptr + 1'b1;
    end
    if (pop)
    begin
      next_st.rptr = st.rptr + 1'b1;
    end
    if (push && !pop)
    begin
      next_st.count = st.count + 1'b1;
    end
    else if (pop && !push)
    begin
      next_st.count = st.count - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end
endmodule

module pmi_mac_if (
  input wire logic clk_sys,
  input wire logic rstn,
  // register port from management logic
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // link state from autonegotiation
  input wire pmi_pkg::pmi_speed_e link_speed,
  input wire logic full_duplex,
  // MAC transmit pins
  input wire logic tx_clk,
  input wire logic [7:0] txd,
  input wire logic tx_en,
  input wire logic tx_er,
  // MAC receive pins
  output logic rx_clk,
  output logic [7:0] rxd,
  output logic rx_dv,
  output logic rx_er,
  output logic crs,
  output logic col,
  // skew control per path, index 0 rx, 1 tx
  output logic [1:0][3:0] skew_code,
  output logic [1:0][11:0] skew_ps,
  // coder side transmit
  output logic [2:0] pcs_tx_sel,
  output logic [7:0] pcs_txd,
  output logic pcs_tx_en,
  output logic pcs_tx_er,
  output logic pcs_tx_stb,
  // coder side receive
  input wire logic line_rx_valid,
  output logic line_rx_ready,
  input wire logic [7:0] line_rx_data,
  input wire logic line_rx_er,
  input wire logic line_rx_dv,
  input wire logic squelch_ok,
  input wire logic signal_detect,
  input wire logic line_bit,
  input wire logic line_bit_en
);

  typedef struct packed {
    logic txc_s1;
    logic txc_s2;
    logic txc_s3;
    logic [7:0] txd_s1;
    logic [7:0] txd_s2;
    logic txen_s1;
    logic txen_s2;
    logic txer_s1;
    logic txer_s2;
    logic [15:0] ctl;
    logic [15:0] dly;
    logic [15:0] rdata;
    logic [3:0] tx_lo;
    logic tx_lo_en;
    logic tx_nib_hi;
    logic [2:0] tx_sel;
    logic [7:0] ptxd;
    logic ptxen;
    logic ptxer;
    logic ptxstb;
    logic rxclk;
    logic [4:0] half_cnt;
    logic rx_nib_hi;
    logic [8:0] rx_word;
    logic rx_have;
    logic [7:0] rxd;
    logic rxdv;
    logic rxer;
    logic z_seen;
    logic one_after;
    logic crs100;
    logic dv_prev;
    logic crs;
    logic col;
  } pmi_state_s;

  pmi_state_s st;
  pmi_state_s next_st;
  logic fifo_valid;
  logic fifo_pop;
  logic [8:0] fifo_data;
  logic rgmii;
  logic wide;
  logic tx_rise;
  logic tx_fall;
  logic rx_toggle;
  logic [4:0] half_len;
  logic rx_crs;

  pmi_fifo #(
    .W(pmi_pkg::FIFO_W),
    .D(pmi_pkg::FIFO_D)
  ) u_rx_fifo (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .in_valid(line_rx_valid),
    .in_ready(line_rx_ready),
    .in_data({line_rx_er, line_rx_data}),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  assign rgmii = st.ctl[pmi_pkg::CTL_RGMII_EN_BIT];
  // a byte per clock period at gigabit, a nibble at 10 and 100 in either mode
  assign wide = (link_speed == pmi_pkg::SPD_1000);
  assign tx_rise = st.txc_s2 & ~st.txc_s3;
  assign tx_fall = ~st.txc_s2 & st.txc_s3;
  assign rx_toggle = (st.half_cnt <= 5'h01);
  // pop only when the clock is about to fall and a new word is due
  assign fifo_pop = rx_toggle & st.rxclk & (wide | ~st.rx_nib_hi);

  always_comb
  begin
    unique case (link_speed)
      pmi_pkg::SPD_1000: half_len = pmi_pkg::HALF_1000;
      pmi_pkg::SPD_100: half_len = pmi_pkg::HALF_100;
      pmi_pkg::SPD_10: half_len = pmi_pkg::HALF_10;
      default: half_len = pmi_pkg::HALF_10;
    endcase
  end

  // shift bit gates the code to zero; each code step adds one quarter ns
  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_skew
      localparam int SB = (i == 0) ? pmi_pkg::CTL_RX_SHIFT_BIT : pmi_pkg::CTL_TX_SHIFT_BIT;
      localparam int CL = (i == 0) ? pmi_pkg::DLY_RX_LSB : pmi_pkg::DLY_TX_LSB;
      logic [3:0] code;
      assign code = st.dly[CL +: pmi_pkg::DLY_CODE_W];
      assign skew_code[i] = st.ctl[SB] ? code : 4'h0;
      assign skew_ps[i] = skew_code[i] * pmi_pkg::SKEW_STEP_PS;
    end
  endgenerate

  assign rx_crs = (link_speed == pmi_pkg::SPD_10) ? squelch_ok :
                  (link_speed == pmi_pkg::SPD_100) ? st.crs100 : line_rx_dv;

  always_comb
  begin
    next_st = st;
    // pins from the MAC cross two flops before use
    next_st.txc_s1 = tx_clk;
    next_st.txc_s2 = st.txc_s1;
    next_st.txc_s3 = st.txc_s2;
    next_st.txd_s1 = txd;
    next_st.txd_s2 = st.txd_s1;
    next_st.txen_s1 = tx_en;
    next_st.txen_s2 = st.txen_s1;
    next_st.txer_s1 = tx_er;
    next_st.txer_s2 = st.txer_s1;

    // register port
    if (reg_wr && reg_addr == pmi_pkg::REG_IF_CTRL)
    begin
      next_st.ctl = (st.ctl & ~pmi_pkg::CTL_WR_MASK) | (reg_wdata & pmi_pkg::CTL_WR_MASK);
    end
    if (reg_wr && reg_addr == pmi_pkg::REG_IF_DELAY)
    begin
      next_st.dly = reg_wdata & pmi_pkg::DLY_WR_MASK;
    end
    if (reg_rd)
    begin
      if (reg_addr == pmi_pkg::REG_IF_CTRL)
      begin
        next_st.rdata = st.ctl;
        next_st.rdata[pmi_pkg::CTL_COL_BIT] = st.col;
        next_st.rdata[pmi_pkg::CTL_CRS_BIT] = st.crs;
        next_st.rdata[pmi_pkg::CTL_SPEED_LSB +: 2] = link_speed;
      end
      else if (reg_addr == pmi_pkg::REG_IF_DELAY)
      begin
        next_st.rdata = st.dly;
      end
      else
      begin
        next_st.rdata = 16'h0000;
      end
    end

    // transmit capture on the MAC clock edges; no edges means no data,
    // so a MAC that parks its clock low until matched is harmless
    next_st.ptxstb = 1'b0;
    next_st.tx_sel = 3'h1 << link_speed;
    if (tx_rise)
    begin
      if (wide && rgmii)
      begin
        next_st.tx_lo = st.txd_s2[3:0];
        next_st.tx_lo_en = st.txen_s2;
      end
      else if (wide)
      begin
        next_st.ptxd = st.txd_s2;
        next_st.ptxen = st.txen_s2;
        next_st.ptxer = st.txer_s2;
        next_st.ptxstb = 1'b1;
      end
      else if (!st.txen_s2)
      begin
        next_st.tx_nib_hi = 1'b0;
        next_st.ptxen = 1'b0;
        next_st.ptxer = 1'b0;
        next_st.ptxstb = 1'b1;
      end
      else if (!st.tx_nib_hi)
      begin
        next_st.tx_lo = st.txd_s2[3:0];
        next_st.tx_nib_hi = 1'b1;
      end
      else
      begin
        next_st.ptxd = {st.txd_s2[3:0], st.tx_lo};
        next_st.ptxen = 1'b1;
        next_st.ptxer = rgmii ? 1'b0 : st.txer_s2;
        next_st.ptxstb = 1'b1;
        next_st.tx_nib_hi = 1'b0;
      end
    end
    else if (tx_fall && wide && rgmii)
    begin
      // falling control carries enable xor error
      next_st.ptxd = {st.txd_s2[3:0], st.tx_lo};
      next_st.ptxen = st.tx_lo_en;
      next_st.ptxer = st.txen_s2 ^ st.tx_lo_en;
      next_st.ptxstb = 1'b1;
    end

    // receive clock: a new half period length only loads at a toggle, so a
    // speed change lets the running phase finish at its old length instead of cutting it short
    if (rx_toggle)
    begin
      next_st.rxclk = ~st.rxclk;
      next_st.half_cnt = half_len;
      if (st.rxclk)
      begin
        // falling edge: set up data for the coming rising edge
        if (wide || !st.rx_nib_hi)
        begin
          next_st.rx_word = fifo_data;
          next_st.rx_have = fifo_valid;
          next_st.rx_nib_hi = ~wide & fifo_valid;
          next_st.rxdv = fifo_valid;
          next_st.rxer = fifo_valid & fifo_data[8] & ~rgmii;
          if (wide && !rgmii)
          begin
            next_st.rxd = fifo_valid ? fifo_data[7:0] : 8'h00;
          end
          else
          begin
            next_st.rxd = {4'h0, fifo_valid ? fifo_data[3:0] : 4'h0};
          end
        end
        else
        begin
          next_st.rx_nib_hi = 1'b0;
          next_st.rxd = {4'h0, st.rx_word[7:4]};
          next_st.rxer = st.rx_word[8] & ~rgmii;
          next_st.rxdv = st.rx_have;
        end
      end
      else if (rgmii)
      begin
        // rising edge: second half of the reduced interface cycle
        next_st.rxdv = st.rx_have ^ (st.rx_have & st.rx_word[8]);
        if (wide)
        begin
          next_st.rxd = {4'h0, st.rx_have ? st.rx_word[7:4] : 4'h0};
        end
        // at 10/100 the nibble simply stays for the falling edge
      end
    end
    else
    begin
      next_st.half_cnt = st.half_cnt - 5'h01;
    end

    // 100M carrier: zero, then a one, then another zero under signal_detect
    next_st.dv_prev = line_rx_dv;
    if (!signal_detect || (st.dv_prev && !line_rx_dv))
    begin
      next_st.z_seen = 1'b0;
      next_st.one_after = 1'b0;
      next_st.crs100 = 1'b0;
    end
    else if (line_bit_en)
    begin
      if (!line_bit && st.z_seen && st.one_after)
      begin
        next_st.crs100 = 1'b1;
      end
      else if (!line_bit)
      begin
        next_st.z_seen = 1'b1;
      end
      else if (st.z_seen)
      begin
        next_st.one_after = 1'b1;
      end
    end

    // carrier and collision
    if (full_duplex || wide)
    begin
      next_st.crs = rx_crs;
      next_st.col = 1'b0;
    end
    else
    begin
      next_st.crs = rx_crs | st.ptxen;
      next_st.col = rx_crs & st.ptxen;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '0;
      st.ctl <= pmi_pkg::CTL_RESET;
      st.dly <= pmi_pkg::DLY_RESET;
      st.half_cnt <= pmi_pkg::HALF_10;
      st.tx_sel <= 3'h1;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign rx_clk = st.rxclk;
  assign rxd = st.rxd;
  assign rx_dv = st.rxdv;
  assign rx_er = st.rxer;
  assign crs = st.crs;
  assign col = st.col;
  assign pcs_tx_sel = st.tx_sel;
  assign pcs_txd = st.ptxd;
  assign pcs_tx_en = st.ptxen;
  assign pcs_tx_er = st.ptxer;
  assign pcs_tx_stb = st.ptxstb;

endmodule

// ===== bench/pmi_mac_if_assertions.sv
// checker: carrier, collision, skew and clock relations at the ports
`timescale 1ns/10ps
module pmi_chk (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire pmi_pkg::pmi_speed_e link_speed,
  input wire logic full_duplex,
  input wire logic squelch_ok,
  input wire logic rx_clk,
  input wire logic crs,
  input wire logic col,
  input wire logic [1:0][3:0] skew_code,
  input wire logic [1:0][11:0] skew_ps,
  input wire logic [2:0] pcs_tx_sel,
  input wire logic pcs_tx_en,
  input wire logic pcs_tx_stb
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  logic sp10, sp1g;
  assign sp10 = link_speed == pmi_pkg::SPD_10;
  assign sp1g = link_speed == pmi_pkg::SPD_1000;
  a_col_full: assert property (
    (full_duplex || sp1g) |=> !col)
    else $error("collision in full duplex");
  a_col_half: assert property (
    (!full_duplex && sp10 && squelch_ok && pcs_tx_en)[*3] |=> col)
    else $error("collision missing");
  a_crs_tx: assert property (
    (!full_duplex && !sp1g && pcs_tx_en)[*2] |=> crs)
    else $error("carrier missing on transmit");
  a_crs_full: assert property (
    (full_duplex && sp10 && !squelch_ok)[*3] |=> !crs)
    else $error("carrier without receive");
  a_skew_linear: assert property (
    skew_ps[0] == 12'(skew_code[0]) * 12'h0fa && skew_ps[1] == 12'(skew_code[1]) * 12'h0fa)
    else $error("skew not linear");
  a_stb_pulse: assert property (
    pcs_tx_stb |=> !pcs_tx_stb)
    else $error("strobe longer than one cycle");
  a_rxclk_half: assert property (
    $rose(rx_clk) && !sp10 && !sp1g && $past(link_speed, 3) == pmi_pkg::SPD_100
    |=> rx_clk ##1 !rx_clk)
    else $error("rx clock half period wrong");
  a_sel_speed: assert property (
    $stable(link_speed) && $past(rstn) |-> pcs_tx_sel == 3'h1 << link_speed)
    else $error("coder select wrong");
endmodule

// ===== bench/pmi_mac_model.sv
// MAC transmit model: nibble frames, clock stands low between frames
`timescale 1ns/10ps
module pmi_mac_model (
  input wire logic speed_ok,
  output logic tx_clk,
  output logic [7:0] txd,
  output logic tx_en,
  output logic tx_er
);
  initial
  begin
    tx_clk = 1'b0;
    txd = 8'h00;
    tx_en = 1'b0;
    tx_er = 1'b0;
  end
  // only whole 400 ns phases, so no runt pulse reaches the pin
  task automatic nib(input logic [3:0] n, input logic en);
    txd <= {~n, n};
    tx_en <= en;
    #400;
    tx_clk <= 1'b1;
    #400;
    tx_clk <= 1'b0;
  endtask
  task automatic send(input logic [7:0] q[$]);
    wait (speed_ok);
    foreach (q[i])
    begin
      nib(q[i][3:0], 1'b1);
      nib(q[i][7:4], 1'b1);
    end
    nib(~txd[3:0], 1'b0);
  endtask
endmodule

// ===== bench/testbench.sv
// testbench: registers, transmit, carrier, collision, receive buffer
`timescale 1ns/10ps
module testbench;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  pmi_pkg::pmi_speed_e link_speed = pmi_pkg::SPD_100;
  logic full_duplex = 1'b0;
  logic speed_ok = 1'b0;
  logic line_rx_valid = 1'b0;
  logic [7:0] line_rx_data = 8'h00;
  logic line_rx_er = 1'b0;
  logic line_rx_dv = 1'b0;
  logic squelch_ok = 1'b0;
  logic signal_detect = 1'b0;
  logic line_bit = 1'b0;
  logic line_bit_en = 1'b0;
  logic tx_clk, tx_en, tx_er, rx_clk, rx_dv, rx_er, crs, col, rx_clk_q;
  logic pcs_tx_en, pcs_tx_er, pcs_tx_stb, line_rx_ready;
  logic [7:0] txd, rxd, pcs_txd;
  logic [15:0] reg_rdata, c, d, v;
  logic [1:0][3:0] skew_code;
  logic [1:0][11:0] skew_ps;
  logic [2:0] pcs_tx_sel;
  logic [7:0] tx_q[$], exp_q[$], b[$];
  logic [3:0] nib_q[$];
  logic [8:0] byte_q[$];
  int num_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  pmi_mac_if pmi_mac_if_inst (.*);
  pmi_mac_model pmi_mac_model_inst (.*);
  always #50 clk_sys = ~clk_sys;
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] w);
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] q);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    q = reg_rdata;
  endtask
  task automatic bits(input logic [2:0] s);
    for (int i = 2; i >= 0; i--)
    begin
      line_bit <= s[i];
      line_bit_en <= 1'b1;
      @(posedge clk_sys);
    end
    line_bit_en <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  function automatic logic [15:0] ctl_exp(input logic [15:0] w);
    return (w & 16'h0083) | {2'h0, link_speed, 12'h000};
  endfunction
  always @(posedge clk_sys)
  begin
    rx_clk_q <= rx_clk;
    cyc <= cyc + 1;
    if (pcs_tx_stb && pcs_tx_en)
      tx_q.push_back(pcs_txd);
    if (rx_clk && !rx_clk_q && rx_dv)
      nib_q.push_back(rxd[3:0]);
    if (rx_clk && !rx_clk_q && rx_dv && link_speed == pmi_pkg::SPD_1000)
      byte_q.push_back({rx_er, rxd});
    if (cyc == 40000)
    begin
      num_errors++;
      finish_test();
    end
  end
  initial
  begin
    void'($urandom(15));
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    rd(16'h0032, v);
    chk(16'h1080, v);
    rd(16'h0086, v);
    chk(16'h0000, v);
    rd(16'h0040, v);
    chk(16'h0000, v);
    for (int i = 0; i < 10; i++)
    begin
      c = (i == 0) ? 16'hffff : 16'($urandom);
      d = (i == 0) ? 16'hffff : 16'($urandom);
      wr(16'h0086, d);
      wr(16'h0032, c);
      wr(16'h0033, ~c);
      rd(16'h0032, v);
      chk(ctl_exp(c), v);
      rd(16'h0086, v);
      chk(d & 16'h00ff, v);
      for (int p = 0; p < 2; p++)
      begin
        chk(c[p] ? 16'(d[4*p+:4]) : 16'h0000, 16'(skew_code[p]));
        chk(c[p] ? 16'(d[4*p+:4]) * 16'h00fa : 16'h0000, 16'(skew_ps[p]));
      end
    end
    $display("register test done");
    wr(16'h0032, 16'h0000);
    speed_ok <= 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      link_speed <= (k == 0) ? pmi_pkg::SPD_100 : pmi_pkg::SPD_10;
      full_duplex <= (k == 2);
      squelch_ok <= 1'b1;
      b = {8'h00, 8'hff};
      repeat (4) b.push_back(8'($urandom));
      tx_q.delete();
      fork
        pmi_mac_model_inst.send(b);
        begin
          wait (pcs_tx_en === 1'b1);
          repeat (4) @(posedge clk_sys);
          chk(16'(k == 1), 16'(col));
          chk(16'h0001, 16'(crs));
          squelch_ok <= 1'b0;
          repeat (4) @(posedge clk_sys);
          chk(16'(k != 2), 16'(crs));
        end
      join
      repeat (8) @(posedge clk_sys);
      chk(16'h0000, 16'(crs));
      chk(16'(3'h1 << link_speed), 16'(pcs_tx_sel));
      chk(16'(b.size()), 16'(tx_q.size()));
      foreach (tx_q[i])
        chk(16'(b[i]), 16'(tx_q[i]));
      $display("transmit case %0d done", k);
    end
    link_speed <= pmi_pkg::SPD_100;
    full_duplex <= 1'b1;
    signal_detect <= 1'b1;
    bits(3'b100);
    chk(16'h0000, 16'(crs));
    bits(3'b010);
    chk(16'h0001, 16'(crs));
    signal_detect <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk(16'h0000, 16'(crs));
    $display("carrier test done");
    link_speed <= pmi_pkg::SPD_10;
    c = 16'h0000;
    while (exp_q.size() < 20)
    begin
      line_rx_valid <= 1'b1;
      line_rx_data <= d[7:0];
      @(negedge clk_sys);
      v[0] = line_rx_ready;
      @(posedge clk_sys);
      if (v[0])
      begin
        exp_q.push_back(d[7:0]);
        d = 16'($urandom);
      end
      else
        c++;
    end
    line_rx_valid <= 1'b0;
    chk(16'h0001, 16'(c != 16'h0000));
    repeat (3000) if (nib_q.size() < 40) @(posedge clk_sys);
    chk(16'h0028, 16'(nib_q.size()));
    foreach (exp_q[i])
      chk(16'(exp_q[i]), 16'({nib_q[2*i+1], nib_q[2*i]}));
    $display("receive test done");
    // gigabit byte path in GMII mode, second byte carries an error flag
    link_speed <= pmi_pkg::SPD_1000;
    d = 16'($urandom);
    for (int i = 0; i < 2; i++)
    begin
      line_rx_valid <= 1'b1;
      line_rx_er <= i[0];
      line_rx_data <= i[0] ? d[7:0] : 8'h3c;
      @(posedge clk_sys);
    end
    line_rx_valid <= 1'b0;
    line_rx_er <= 1'b0;
    repeat (40) @(posedge clk_sys);
    chk(16'h0002, 16'(byte_q.size()));
    chk(16'h003c, 16'(byte_q[0]));
    chk({7'h00, 1'b1, d[7:0]}, 16'(byte_q[1]));
    $display("gigabit receive test done");
    finish_test();
  end
endmodule
bind pmi_mac_if pmi_chk pmi_chk_inst (.*);
